// file: rtl/dcpm_top.sv
// dcpm_top: clock source select, divider, crystal control and switchback.
// assumes i_clk is the 25 mhz model clock; clocks go out as enables, and
// only the crystal input is asynchronous and synchronised here.
`include "dcpm_map.svh"
module dcpm_top
  import dcpm_pkg::*;
(
  // clock and resets
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_por_b,
  // register port
  input  wire dcpm_pkg::dcpm_bus_s   i_bus,
  output logic [31:0]                o_rdata,
  // crystal and fll
  input  wire logic                  i_crystal_input,
  // power state from the cores
  input  wire logic                  i_stop_req,
  input  wire logic                  i_stop_wake,
  input  wire logic                  i_signal_core_on,
  input  wire logic                  i_precise_busy,
  // switchback events
  input  wire dcpm_pkg::dcpm_evt_s   i_evt,
  // clock enables and state
  output dcpm_pkg::dcpm_clk_s        o_clk,
  output logic                       o_in_stop,
  output logic                       o_run,
  output logic [15:0]                o_start_vector
);
  import dcpm_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic        fll_select;
    logic        lock_request;
    logic [1:0]  clock_divide_select;
    logic        low_power_divide_enable;
    logic        switchback_enable;
    logic [1:0]  saved_cdiv;
    logic        crystal_amp_disable;
    dcpm_xmode_e crystal_mode;
    logic        crystal_ready;
    logic [22:0] warm_cnt;
    logic        power_on_flag;
    logic [16:0] por_cnt;
    logic        run;
    logic        in_stop;
    logic        conv_d;
    logic        wake_hold;
    logic [7:0]  since;
    logic        last_x;
    logic        half;
    logic [2:0]  xsync;
    logic [31:0] rdata;
    dcpm_clk_s   clk;
  } dcpm_state_s;

  dcpm_state_s r;
  dcpm_state_s next_r;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic       lock_indicator;
  dcpm_fll_e  fll_state;
  logic       div_tick;
  logic [3:0] div_shift_now;
  logic [3:0] div_shift;
  logic       xtal_tick;
  logic       xtal_direct;
  logic       hf_on;
  logic       quiet;
  logic       sb_event;
  logic       wr_cc;
  logic       wr_xc;
  logic       wr_clr;
  logic       pulse_x;
  logic       src_ok;
  logic       i_por_b_q;

  // power-on-only bits live in a separate flop set, untouched by i_rst_b
  logic       por_fll_select;
  logic       por_amp_disable;
  logic       por_flag;

  assign xtal_tick   = r.xsync[2] & ~r.xsync[1];
  assign xtal_direct = r.low_power_divide_enable && (r.clock_divide_select == 2'h3);
  assign hf_on       = !xtal_direct || r.switchback_enable || i_signal_core_on;
  assign wr_cc       = i_bus.wr && (i_bus.addr == `DCPM_OFS_CLK_CTRL);
  assign wr_xc       = i_bus.wr && (i_bus.addr == `DCPM_OFS_XTAL_CTRL);
  assign wr_clr      = i_bus.wr && (i_bus.addr == `DCPM_OFS_FLAG_CLR);
  assign pulse_x     = xtal_direct || !r.fll_select;
  // a source change waits until 255 cycles have passed since the last pulse, so no pulse comes early
  assign src_ok      = (pulse_x == r.last_x) || (r.since == 8'hff);

  // quiet by setting, or by stop entry with the upper mode bit set
  assign quiet = (r.crystal_mode == DCPM_XM_QUIET) ||
                 (r.in_stop && !r.wake_hold && r.crystal_mode[1]);

  always_comb
  begin
    if (!r.low_power_divide_enable)
    begin
      div_shift = {2'h0, r.clock_divide_select};
    end
    else
    begin
      div_shift = 4'h8;
    end
  end

  // switchback qualifiers
  assign sb_event = i_evt.ext_int_edge ||
                    (i_evt.uart_rx_en && i_evt.uart_rx_edge) ||
                    i_evt.serial_buffer_wr ||
                    (i_evt.spi_buffer_wr && i_evt.spi_master && i_evt.master_standby) ||
                    (!i_evt.spi_master && i_evt.slave_select_pin) ||
                    (i_evt.i2c_start_irq && i_evt.start_irq_enable) ||
                    (i_evt.start_command_bit_wr && i_evt.controller_master_select) ||
                    (i_evt.conversion_start_bit && !r.conv_d) ||
                    i_evt.rtc_alarm ||
                    (i_evt.supply_monitor_irq && i_evt.supply_monitor_irq_enable) ||
                    i_evt.debug_entry;

  dcpm_fll u_fll (
    .i_clk            (i_clk),
    .i_rst_b          (i_por_b),
    .i_lock_request   (r.lock_request),
    .i_hf_on          (hf_on),
    .i_xtal_tick      (xtal_tick),
    .o_lock_indicator (lock_indicator),
    .o_state          (fll_state)
  );

  dcpm_clkdiv u_div (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_shift     (div_shift),
    .o_tick      (div_tick),
    .o_shift_now (div_shift_now)
  );

  // ------------------------------------------------------------
  // power-on-only bits
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_por_b)
  begin
    if (!i_por_b)
    begin
      por_fll_select  <= 1'b0;
      por_amp_disable <= 1'b0;
      por_flag        <= 1'b1;
    end
    else if (wr_clr && i_bus.wdata[`DCPM_ST_POR])
    begin
      por_flag <= 1'b0;
    end
    else if (wr_cc)
    begin
      por_fll_select <= i_bus.wdata[`DCPM_CC_FLLSEL];
    end
    else if (wr_xc)
    begin
      por_amp_disable <= i_bus.wdata[`DCPM_XC_AMPDIS];
    end
  end

  // ------------------------------------------------------------
  // main next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.fll_select          = por_fll_select;
    next_r.crystal_amp_disable = por_amp_disable;
    next_r.power_on_flag       = por_flag;
    next_r.xsync  = {r.xsync[1:0], i_crystal_input};
    next_r.conv_d = i_evt.conversion_start_bit;

    if (wr_cc)
    begin
      next_r.lock_request        = i_bus.wdata[`DCPM_CC_LOCKREQ];
      next_r.clock_divide_select = i_bus.wdata[`DCPM_CC_CDIV_HI:`DCPM_CC_CDIV_LO];
      next_r.switchback_enable   = i_bus.wdata[`DCPM_CC_SWB];
      if (i_bus.wdata[`DCPM_CC_LPDE] && !r.low_power_divide_enable)
      begin
        if (!i_precise_busy)
        begin
          next_r.low_power_divide_enable = 1'b1;
          next_r.saved_cdiv = r.clock_divide_select;
        end
      end
      else
      begin
        next_r.low_power_divide_enable = i_bus.wdata[`DCPM_CC_LPDE];
      end
    end
    if (wr_xc)
    begin
      next_r.crystal_mode = dcpm_xmode_e'(i_bus.wdata[`DCPM_XC_MODE_HI:`DCPM_XC_MODE_LO]);
    end

    // switchback: restore the settings held on low-power entry
    if (r.low_power_divide_enable && r.switchback_enable && sb_event)
    begin
      next_r.low_power_divide_enable = 1'b0;
      next_r.clock_divide_select     = r.saved_cdiv;
    end

    // crystal warmup; enable and quiet-exit both restart it
    if (r.crystal_amp_disable)
    begin
      next_r.crystal_ready = 1'b0;
      next_r.warm_cnt      = 23'h0;
    end
    else if (quiet)
    begin
      next_r.crystal_ready = 1'b1;
      next_r.warm_cnt      = 23'h0;
    end
    else if (r.clk.xtal_quiet)
    begin
      next_r.crystal_ready = 1'b0;
      next_r.warm_cnt      = 23'h0;
    end
    else if (!r.crystal_ready)
    begin
      if (r.warm_cnt == 23'(`DCPM_WARMUP_CYC - 1))
      begin
        next_r.crystal_ready = 1'b1;
      end
      else
      begin
        next_r.warm_cnt = r.warm_cnt + 23'h1;
      end
    end

    // stop entry and exit
    if (i_stop_req && r.run)
    begin
      next_r.in_stop = 1'b1;
    end
    else if (r.in_stop && i_stop_wake && !r.wake_hold)
    begin
      if (r.crystal_mode == DCPM_XM_QUIET_STOP_HOLD && !r.crystal_amp_disable)
      begin
        // the oscillator leaves quiet now; the core stays stopped until ready
        next_r.wake_hold = 1'b1;
      end
      else
      begin
        next_r.in_stop = 1'b0;
      end
    end
    else if (r.wake_hold && (next_r.crystal_ready || r.crystal_amp_disable))
    begin
      next_r.in_stop   = 1'b0;
      next_r.wake_hold = 1'b0;
    end
    if (!r.run && !r.in_stop && r.power_on_flag == 1'b0 && r.por_cnt == 17'h0)
    begin
      // after an i_rst_b reset with the power-on flag clear, run waits for crystal ready
      next_r.run = next_r.crystal_ready;
    end

    // power-on delay counted in fll cycles (modelled as system cycles)
    if (r.por_cnt != 17'h0)
    begin
      next_r.por_cnt = r.por_cnt - 17'h1;
      if (r.por_cnt == 17'h1)
      begin
        next_r.run = 1'b1;
      end
    end

    // clock enables: the divided i_clk is the fast source, the crystal tick the slow one
    next_r.half = div_tick ? ~r.half : r.half;
    next_r.clk.hf_run         = hf_on && (fll_state != DCPM_FLL_OFF);
    next_r.clk.xtal_amp_en    = !r.crystal_amp_disable;
    next_r.clk.xtal_quiet     = quiet;
    if (pulse_x)
    begin
      next_r.clk.signal_core_en = r.run && !r.in_stop && xtal_tick && src_ok;
    end
    else
    begin
      next_r.clk.signal_core_en = r.run && !r.in_stop && div_tick && src_ok;
    end
    next_r.clk.supervisor_core_en = next_r.clk.signal_core_en &&
                                    (pulse_x ? r.half : !r.half);
    if (next_r.clk.signal_core_en)
    begin
      next_r.since  = 8'h00;
      next_r.last_x = pulse_x;
    end
    else if (r.since != 8'hff)
    begin
      next_r.since = r.since + 8'h01;
    end

    // register readback, one cycle after the read strobe
    next_r.rdata = 32'h0;
    if (i_bus.rd)
    begin
      if (i_bus.addr == `DCPM_OFS_CLK_CTRL)
      begin
        next_r.rdata[`DCPM_CC_FLLSEL]  = r.fll_select;
        next_r.rdata[`DCPM_CC_LOCKREQ] = r.lock_request;
        next_r.rdata[`DCPM_CC_CDIV_HI:`DCPM_CC_CDIV_LO] = r.clock_divide_select;
        next_r.rdata[`DCPM_CC_LPDE]    = r.low_power_divide_enable;
        next_r.rdata[`DCPM_CC_SWB]     = r.switchback_enable;
      end
      else if (i_bus.addr == `DCPM_OFS_XTAL_CTRL)
      begin
        next_r.rdata[`DCPM_XC_AMPDIS] = r.crystal_amp_disable;
        next_r.rdata[`DCPM_XC_MODE_HI:`DCPM_XC_MODE_LO] = r.crystal_mode;
      end
      else if (i_bus.addr == `DCPM_OFS_STATUS)
      begin
        next_r.rdata[`DCPM_ST_XRDY]  = r.crystal_ready;
        next_r.rdata[`DCPM_ST_LOCK]  = lock_indicator;
        next_r.rdata[`DCPM_ST_POR]   = r.power_on_flag;
        next_r.rdata[`DCPM_ST_RUN]   = r.run;
        next_r.rdata[`DCPM_ST_HF_ON] = r.clk.hf_run;
        next_r.rdata[`DCPM_ST_QUIET] = r.clk.xtal_quiet;
        next_r.rdata[`DCPM_ST_HOLD]  = (div_shift_now != div_shift);
      end
    end
  end

  // ------------------------------------------------------------
  // registers; power_on_flag and por_cnt are only set by i_por_b
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r <= '0;
      r.crystal_mode        <= dcpm_xmode_e'(`DCPM_RST_XMODE);
      r.clock_divide_select <= `DCPM_RST_CDIV;
      r.low_power_divide_enable <= 1'b0;
    end
    else if (!r.power_on_flag && !r.run && r.por_cnt == 17'h0 && !i_por_b_q)
    begin
      r <= next_r;
      r.power_on_flag <= 1'b1;
      r.por_cnt       <= 17'(`DCPM_POR_FLL_CYC);
    end
    else
    begin
      r <= next_r;
    end
  end

  // power-on seen since last clocked edge, caught after release
  always_ff @(posedge i_clk or negedge i_por_b)
  begin
    if (!i_por_b)
    begin
      i_por_b_q <= 1'b0;
    end
    else
    begin
      i_por_b_q <= 1'b1;
    end
  end

  assign o_rdata        = r.rdata;
  assign o_clk          = r.clk;
  assign o_in_stop      = r.in_stop;
  assign o_run          = r.run;
  assign o_start_vector = `DCPM_RESET_VECTOR;
endmodule

// file: rtl/dcpm_map.svh
// dcpm_map.svh: offsets, field positions, reset values and timing counts of
// the clock and power manager. assumes a 25 mhz i_clk.
`ifndef DCPM_MAP_SVH
`define DCPM_MAP_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define DCPM_OFS_CLK_CTRL   8'h00
`define DCPM_OFS_XTAL_CTRL  8'h04
`define DCPM_OFS_STATUS     8'h08
`define DCPM_OFS_FLAG_CLR   8'h0c

// ------------------------------------------------------------
// clock control fields
// ------------------------------------------------------------
`define DCPM_CC_FLLSEL      0
`define DCPM_CC_LOCKREQ     1
`define DCPM_CC_CDIV_LO     2
`define DCPM_CC_CDIV_HI     3
`define DCPM_CC_LPDE        4
`define DCPM_CC_SWB         5

// ------------------------------------------------------------
// crystal control fields
// ------------------------------------------------------------
`define DCPM_XC_AMPDIS      0
`define DCPM_XC_MODE_LO     1
`define DCPM_XC_MODE_HI     2

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define DCPM_ST_XRDY        0
`define DCPM_ST_LOCK        1
`define DCPM_ST_POR         2
`define DCPM_ST_RUN         3
`define DCPM_ST_HF_ON       4
`define DCPM_ST_QUIET       5
`define DCPM_ST_HOLD        6

// ------------------------------------------------------------
// reset values and vector
// ------------------------------------------------------------
`define DCPM_RST_CDIV       2'h0
`define DCPM_RST_XMODE      2'h0
`define DCPM_RESET_VECTOR   16'h8000

// ------------------------------------------------------------
// timing: times in their own unit, the warmup count derived from 25 mhz
// ------------------------------------------------------------
`define DCPM_CLK_HZ         25000000
`define DCPM_WARMUP_MS      250
`define DCPM_WARMUP_CYC     ((`DCPM_CLK_HZ / 1000) * `DCPM_WARMUP_MS)
`define DCPM_LOCK_XTAL_CYC  64
`define DCPM_POR_FLL_CYC    65536
`define DCPM_FLL_MULT       306
`define DCPM_LP_DIV         256

`endif

// file: rtl/dcpm_pkg.sv
// dcpm_pkg: types shared by the clock and power manager files.
// assumes dcpm_map.svh holds all numbers.
package dcpm_pkg;

  typedef enum logic [1:0] {
    DCPM_XM_NOISE_IMMUNE,
    DCPM_XM_QUIET,
    DCPM_XM_QUIET_STOP_HOLD,
    DCPM_XM_QUIET_STOP_RUN
  } dcpm_xmode_e;

  typedef enum logic [1:0] {
    DCPM_FLL_OFF,
    DCPM_FLL_WARM,
    DCPM_FLL_LOCKING,
    DCPM_FLL_LOCKED
  } dcpm_fll_e;

  // register port of the block
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dcpm_bus_s;

  // switchback event sources, each a same-clock level or pulse
  typedef struct packed {
    logic ext_int_edge;
    logic uart_rx_edge;
    logic uart_rx_en;
    logic serial_buffer_wr;
    logic spi_buffer_wr;
    logic spi_master;
    logic master_standby;
    logic slave_select_pin;
    logic i2c_start_irq;
    logic start_irq_enable;
    logic start_command_bit_wr;
    logic controller_master_select;
    logic conversion_start_bit;
    logic rtc_alarm;
    logic supply_monitor_irq;
    logic supply_monitor_irq_enable;
    logic debug_entry;
  } dcpm_evt_s;

  // clock enables delivered to the consumers
  typedef struct packed {
    logic signal_core_en;
    logic supervisor_core_en;
    logic hf_run;
    logic xtal_amp_en;
    logic xtal_quiet;
  } dcpm_clk_s;

endpackage

// file: rtl/dcpm_fll.sv
// dcpm_fll: fll lock sequencer, counts crystal periods after a lock request.
// assumes the crystal tick is already synchronised to i_clk.
`include "dcpm_map.svh"
module dcpm_fll
  import dcpm_pkg::*;
(
  // clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst_b,
  // control
  input  wire logic           i_lock_request,
  input  wire logic           i_hf_on,
  input  wire logic           i_xtal_tick,
  // status
  output logic                o_lock_indicator,
  output dcpm_pkg::dcpm_fll_e o_state
);
  import dcpm_pkg::*;

  typedef struct packed {
    dcpm_fll_e  st;
    logic [6:0] cnt;
    logic       lock;
  } dcpm_fll_s;

  dcpm_fll_s r;
  dcpm_fll_s next_r;

  always_comb
  begin
    next_r = r;
    case (r.st)
      DCPM_FLL_OFF:
      begin
        if (i_hf_on)
        begin
          next_r.st = DCPM_FLL_WARM;
        end
      end
      DCPM_FLL_WARM:
      begin
        // free running but unlocked: the indicator stays low
        if (i_lock_request && i_xtal_tick)
        begin
          next_r.st  = DCPM_FLL_LOCKING;
          next_r.cnt = 7'h00;
        end
      end
      DCPM_FLL_LOCKING:
      begin
        if (i_xtal_tick)
        begin
          next_r.cnt = r.cnt + 7'h01;
          if (r.cnt == 7'(`DCPM_LOCK_XTAL_CYC - 1))
          begin
            next_r.st = DCPM_FLL_LOCKED;
          end
        end
      end
      default:
      begin
      end
    endcase
    if (!i_lock_request && r.st != DCPM_FLL_OFF)
    begin
      next_r.st = DCPM_FLL_WARM;
    end
    if (!i_hf_on)
    begin
      next_r.st = DCPM_FLL_OFF;
    end
    next_r.lock = (next_r.st == DCPM_FLL_LOCKED);
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r <= '{st: DCPM_FLL_OFF, cnt: 7'h00, lock: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_lock_indicator = r.lock;
  assign o_state          = r.st;
endmodule

// file: rtl/dcpm_clkdiv.sv
// dcpm_clkdiv: divide-ratio counter giving glitch-free clock enables.
// assumes ratio changes are only applied at a period boundary by this module.
`include "dcpm_map.svh"
module dcpm_clkdiv
  import dcpm_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // ratio request: log2 of the divisor, 0..8
  input  wire logic [3:0] i_shift,
  // outputs
  output logic            o_tick,
  output logic [3:0]      o_shift_now
);
  import dcpm_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic [3:0] shift;
    logic       tick;
  } dcpm_div_s;

  dcpm_div_s  r;
  dcpm_div_s  next_r;
  logic [7:0] last;

  always_comb
  begin
    next_r = r;
    last   = 8'((9'h001 << r.shift) - 9'h001);
    next_r.tick = 1'b0;
    if (r.cnt >= last)
    begin
      // a new ratio is only picked up here, so no period is cut short
      next_r.cnt   = 8'h00;
      next_r.tick  = 1'b1;
      next_r.shift = i_shift;
    end
    else
    begin
      next_r.cnt = r.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r <= '{cnt: 8'h00, shift: 4'h0, tick: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_tick      = r.tick;
  assign o_shift_now = r.shift;
endmodule

// file: sim/dcpm_sva.sv
// dcpm_sva: port-level checks of the clock and power manager.
// assumes it is bound to dcpm_top and sees only its ports.
module dcpm_sva
  import dcpm_pkg::*;
(
  // clock and resets
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire logic                i_por_b,
  // register port
  input  wire dcpm_pkg::dcpm_bus_s i_bus,
  input  wire logic [31:0]         o_rdata,
  // outputs
  input  wire dcpm_pkg::dcpm_clk_s o_clk,
  input  wire logic                o_run,
  input  wire logic [15:0]         o_start_vector
);
  logic [16:0] por_cnt;
  logic [9:0]  gap;
  logic        st_q;

  // gap starts saturated so the first pulse after reset is not judged
  always_ff @(posedge i_clk or negedge i_por_b)
    if (!i_por_b)
      por_cnt <= 17'h0;
    else if (por_cnt != 17'h1ffff)
      por_cnt <= por_cnt + 17'h1;

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      gap  <= 10'h3ff;
      st_q <= 1'b0;
    end
    else
    begin
      gap  <= o_clk.signal_core_en ? 10'h1 : gap + {9'h0, gap != 10'h3ff};
      st_q <= i_bus.rd && i_bus.addr == 8'h08 && o_clk.xtal_quiet;
    end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sup_in_sys_a: assert property (o_clk.supervisor_core_en |-> o_clk.signal_core_en)
    else $error("supervisor enable alone");
  sup_half_a: assert property (o_clk.supervisor_core_en |=> !o_clk.supervisor_core_en)
    else $error("supervisor enable too fast");
  vec_fix_a: assert property (o_start_vector == 16'h8000)
    else $error("start vector wrong");
  run_wait_a: assert property (por_cnt < 17'hfde8 |-> !o_run)
    else $error("run too early");
  amp_por_a: assert property (por_cnt != 17'h0 && por_cnt < 17'h10 |-> o_clk.xtal_amp_en)
    else $error("amplifier off after power-on");
  quiet_rdy_a: assert property (st_q |-> o_rdata[0])
    else $error("ready low in quiet mode");
  gap_ok_a: assert property (o_clk.signal_core_en |->
    (gap inside {10'h1, 10'h2, 10'h4, 10'h8} || gap >= 10'h100))
    else $error("short clock period");
  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data outside slot");
endmodule

bind dcpm_top dcpm_sva u_dcpm_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b),
  .i_bus(i_bus), .o_rdata(o_rdata), .o_clk(o_clk), .o_run(o_run),
  .o_start_vector(o_start_vector));

// file: sim/dcpm_xtal.sv
// dcpm_xtal: 32 khz crystal seen through the amplifier.
// assumes the amplifier enable comes from the block under test.
module dcpm_xtal
(
  // amplifier
  input  wire logic i_amp_en,
  // crystal level
  output logic      o_crystal_input
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_crystal_input = 1'b0;
    forever
    begin
      #15259;
      // a disabled amplifier leaves the pin at rest
      o_crystal_input = i_amp_en ? ~o_crystal_input : 1'b0;
    end
  end
endmodule

// file: sim/tb.sv
// tb: register-level tests of the clock and power manager.
// assumes the crystal model and the bound checker are compiled alongside.
`define CK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t %h %h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcpm_pkg::*;
  logic        i_clk = 0, i_rst_b = 0, i_por_b = 0, i_stop_req = 0, i_stop_wake = 0;
  logic        i_signal_core_on = 0, i_precise_busy = 0, o_in_stop, o_run, xin;
  dcpm_bus_s   i_bus = '0;
  dcpm_evt_s   i_evt = '0;
  dcpm_clk_s   o_clk;
  logic [31:0] o_rdata, rd;
  logic [15:0] o_start_vector;
  // last three events lack their enable and must not switch back
  logic [16:0] ev [14] = '{17'h10000, 17'h0c000, 17'h02000, 17'h01c00, 17'h00200,
    17'h00180, 17'h00060, 17'h00010, 17'h00008, 17'h00006, 17'h00001, 17'h08000,
    17'h00100, 17'h00004};
  int          fails = 0, samples_checked = 0, n;

  dcpm_top u_dcpm_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_crystal_input(xin), .i_stop_req(i_stop_req),
    .i_stop_wake(i_stop_wake), .i_signal_core_on(i_signal_core_on),
    .i_precise_busy(i_precise_busy), .i_evt(i_evt), .o_clk(o_clk), .o_in_stop(o_in_stop),
    .o_run(o_run), .o_start_vector(o_start_vector));
  dcpm_xtal u_dcpm_xtal (.i_amp_en(o_clk.xtal_amp_en), .o_crystal_input(xin));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_bus <= '0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus <= '0;
    #1 rd = o_rdata;
  endtask

  // cycles between enable pulses; third gap so a ratio change has landed
  task automatic gap(input bit s, output int c);
    repeat (3)
    begin
      c = 0;
      do
      begin
        @(posedge i_clk);
        #1 c++;
      end while ((s ? o_clk.supervisor_core_en : o_clk.signal_core_en) !== 1'b1 && c < 2000);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial forever #20 i_clk = ~i_clk;

  initial
  begin
    #8000000;
    fails++;
    test_done();
  end

  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1;
    i_por_b <= 1;
    wr(8'h00, 32'h2);
    rdr(8'h08);
    `CK(rd[2:0], 3'h4)
    `CK({o_run, o_start_vector}, 17'h08000)
    n = 0;
    while (o_run !== 1'b1 && n < 70000)
    begin
      @(posedge i_clk);
      n++;
    end
    `CK(n inside {[65000:66000]}, 1'b1)
    rdr(8'h08);
    `CK(rd[1], 1'b1)
    rdr(8'h10);
    `CK(rd, 32'h0)
    gap(0, n);
    `CK(n inside {[700:800]}, 1'b1)
    for (int k = 0; k < 7; k++)
    begin
      wr(8'h00, {27'h0, k[2], k[1:0], 2'b11});
      gap(0, n);
      `CK(n, k < 4 ? 1 << k : 256)
      gap(1, n);
      `CK(n, k < 4 ? 2 << k : 512)
    end
    wr(8'h00, 32'h1f);
    gap(0, n);
    `CK({n inside {[700:800]}, o_clk.hf_run}, 2'b10)
    i_signal_core_on <= 1;
    repeat (4) @(posedge i_clk);
    `CK(o_clk.hf_run, 1'b1)
    i_signal_core_on <= 0;
    wr(8'h00, 32'h3f);
    repeat (4) @(posedge i_clk);
    `CK(o_clk.hf_run, 1'b1)
    for (int k = 0; k < 14; k++)
    begin
      wr(8'h00, 32'h2f);
      wr(8'h00, 32'h33);
      @(posedge i_clk);
      i_evt <= dcpm_evt_s'(ev[k]);
      @(posedge i_clk);
      i_evt <= '0;
      repeat (4) @(posedge i_clk);
      rdr(8'h00);
      `CK(rd, k < 11 ? 32'h2f : 32'h33)
    end
    wr(8'h00, 32'h2f);
    i_precise_busy <= 1;
    wr(8'h00, 32'h33);
    rdr(8'h00);
    `CK(rd, 32'h23)
    i_precise_busy <= 0;
    wr(8'h04, 32'h2);
    rdr(8'h08);
    `CK({o_clk.xtal_quiet, rd[0]}, 2'b11)
    wr(8'h04, 32'h0);
    rdr(8'h08);
    `CK({o_clk.xtal_quiet, rd[0]}, 2'b00)
    for (int m = 3; m > 1; m--)
    begin
      wr(8'h04, 32'(m << 1));
      i_stop_req <= 1;
      @(posedge i_clk);
      i_stop_req <= 0;
      repeat (4) @(posedge i_clk);
      `CK({o_in_stop, o_clk.xtal_quiet}, 2'b11)
      i_stop_wake <= 1;
      @(posedge i_clk);
      i_stop_wake <= 0;
      n = 0;
      while (o_in_stop === 1'b1 && n < (m == 3 ? 30000 : 500))
      begin
        @(posedge i_clk);
        n++;
      end
      `CK(o_in_stop, m == 2)
    end
    wr(8'h04, 32'h1);
    repeat (2) @(posedge i_clk);
    #1;
    `CK(o_clk.xtal_amp_en, 1'b0)
    wr(8'h00, 32'h11);
    i_rst_b <= 0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1;
    rdr(8'h00);
    `CK({rd[4], rd[0]}, 2'b01)
    rdr(8'h04);
    `CK(rd[0], 1'b1)
    i_rst_b <= 0;
    i_por_b <= 0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1;
    i_por_b <= 1;
    rdr(8'h00);
    `CK({rd[0], o_clk.xtal_amp_en}, 2'b01)
    test_done();
  end
endmodule
